// File: hw/dsl_pkg.sv
package dsl_pkg;

  localparam int WORD_W = 24;

  // Destination of a serial word, taken from its two lowest bits
  typedef enum logic [1:0] {
    SEL_IF_REF = 2'b00,
    SEL_IF_FB  = 2'b01,
    SEL_RF_REF = 2'b10,
    SEL_RF_FB  = 2'b11
  } dsl_sel_t;

  // Reference latch, bit 23 down to bit 0
  typedef struct packed {
    logic [2:0]  pump_current;
    logic        out_sel_hi;
    logic        out_sel_lo;
    logic        pump_tristate;
    logic        pd_polarity;
    logic [14:0] ref_count;
    logic [1:0]  sel;
  } dsl_ref_latch_t;

  // Feedback latch, bit 23 down to bit 0
  typedef struct packed {
    logic        gain;
    logic        powerdown;
    logic [1:0]  prescale_sel;
    logic [11:0] b_count;
    logic [5:0]  a_count;
    logic [1:0]  sel;
  } dsl_fb_latch_t;

  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;

  // Output multiplexer codes: {rf_hi, rf_lo, if_hi, if_lo}
  typedef enum logic [3:0] {
    MUX_LOW       = 4'h0,
    MUX_IF_DLOCK  = 4'h1,
    MUX_IF_ALOCK  = 4'h2,
    MUX_IF_RST    = 4'h3,
    MUX_RF_DLOCK  = 4'h4,
    MUX_RF_ALOCK  = 4'h8,
    MUX_RF_RST    = 4'hc,
    MUX_BOTH_ALOCK = 4'ha,
    MUX_BOTH_RST  = 4'hf,
    MUX_FASTLOCK  = 4'h5
  } dsl_mux_t;

  typedef enum logic [1:0] {
    PD_ACTIVE = 2'b00,
    PD_DRAIN  = 2'b01,
    PD_DOWN   = 2'b10
  } dsl_pd_state_t;

  // Pump current code used while fast-lock is on
  localparam logic [2:0] CP_CURRENT_MAX = 3'h7;

  // Prescaler moduli P of P/P+1, indexed by the two prescaler bits
  localparam logic [6:0] PRESC_SEL0 = 7'h08;
  localparam logic [6:0] PRESC_SEL1 = 7'h10;
  localparam logic [6:0] PRESC_SEL2 = 7'h20;
  localparam logic [6:0] PRESC_SEL3 = 7'h40;

  // Per-side controls handed to the analog and divider sections
  typedef struct packed {
    logic        pump_tristate;
    logic [2:0]  pump_current;
    logic        pd_polarity;
    logic        counters_load;
    logic        input_debias;
    logic        fastlock;
    logic [6:0]  prescaler_mod;
    logic [14:0] ref_count;
    logic [11:0] b_count;
    logic [5:0]  a_count;
  } dsl_side_t;

  function automatic logic [6:0] prescaler_lookup(input logic [1:0] sel);
    unique case (sel)
      2'b00: prescaler_lookup = PRESC_SEL0;
      2'b01: prescaler_lookup = PRESC_SEL1;
      2'b10: prescaler_lookup = PRESC_SEL2;
      2'b11: prescaler_lookup = PRESC_SEL3;
    endcase
  endfunction

endpackage

// File: hw/dsl_sync.sv
`timescale 1ns/10ps
module dsl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: hw/dsl_shift_in.sv
`timescale 1ns/10ps
module dsl_shift_in
  import dsl_pkg::*;
(
  input  wire logic              serial_clk,
  input  wire logic              serial_data,
  output logic      [WORD_W-1:0] shift_word
);

  // No reset: the device has no reset pin, and every frame refills all bits
  always_ff @(posedge serial_clk) begin
    shift_word <= {shift_word[WORD_W-2:0], serial_data};
  end

endmodule

// File: hw/dsl_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - MSB first, shift on clock, latch on strobe
// - Select 0,0 loads IF reference latch
// - Select 0,1 loads IF feedback latch
// - Select 1,0 loads RF reference latch
// - Select 1,1 loads RF feedback latch
// - Analog lock: high with low pulses
// - Combined analog lock needs both loops locked
// - Counter reset modes reset counters, tristate pump
// - Counters restart aligned after reset release
// - Fast-lock mode grounds damping resistor via pin
// - IF power-down with pump active: tristate first
// - RF power-down with pump active: tristate first
// - IF power-down with pump tristated: immediate
// - RF power-down with pump tristated: immediate
// - Power-down loads dividers, debiases input section
// - Reference oscillator off only when both down
// - Shift register and latches work in power-down
// - Writing power-down zero resumes at once
// - Tristate bit places pump in three-state
// - Each pump current from three-bit field
// - Gain bit forces maximum current, fast-lock
// - Prescaler value from two feedback bits
module dsl_ctrl
  import dsl_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           serial_clk,
  input  wire logic           serial_data,
  input  wire logic           latch_load_strobe,
  input  wire logic           if_dlock_in,
  input  wire logic           rf_dlock_in,
  input  wire logic           if_alock_in,
  input  wire logic           rf_alock_in,
  input  wire logic           pfd_pulse_in,
  output dsl_ref_latch_t      if_ref_latch,
  output dsl_fb_latch_t       if_fb_latch,
  output dsl_ref_latch_t      rf_reference_divider_latch,
  output dsl_fb_latch_t       rf_feedback_divider_latch,
  output dsl_side_t           if_side,
  output dsl_side_t           rf_side,
  output logic                if_counter_align,
  output logic                rf_counter_align,
  output logic                ref_osc_disable,
  output dsl_pd_state_t       if_pd_state,
  output dsl_pd_state_t       rf_pd_state,
  output logic                multiplexed_output_pin_o,
  output logic                multiplexed_output_pin_oe
);

  logic [WORD_W-1:0] shift_word;
  logic [5:0]        sync_in;
  logic [5:0]        sync_out;
  logic              strobe_s;
  logic              strobe_d;
  logic              strobe_rise;
  logic              if_dlock;
  logic              rf_dlock;
  logic              if_alock;
  logic              rf_alock;
  logic              pfd_pulse;
  dsl_sel_t          word_sel;
  dsl_mux_t          mux_mode;
  logic              if_reset_mode;
  logic              rf_reset_mode;
  logic              if_reset_d;
  logic              rf_reset_d;
  logic              fastlock_on;
  dsl_pd_state_t     next_if_pd;
  dsl_pd_state_t     next_rf_pd;
  logic              next_pin_o;
  logic              next_pin_oe;

  // Serial side runs on the host's own clock
  dsl_shift_in u_shift (
    .serial_clk  (serial_clk),
    .serial_data (serial_data),
    .shift_word  (shift_word)
  );

  assign sync_in = {latch_load_strobe, if_dlock_in, rf_dlock_in,
                    if_alock_in, rf_alock_in, pfd_pulse_in};

  dsl_sync #(.WIDTH(6)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  assign strobe_s  = sync_out[5];
  assign if_dlock  = sync_out[4];
  assign rf_dlock  = sync_out[3];
  assign if_alock  = sync_out[2];
  assign rf_alock  = sync_out[1];
  assign pfd_pulse = sync_out[0];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= strobe_s;
    end
  end

  assign strobe_rise = strobe_s & ~strobe_d;

  // The shift word is only read at a synchronised strobe rise: the host
  // holds the serial clock still while the strobe is high, so the word
  // has long settled. A host that clocks during the strobe breaks this.
  assign word_sel = dsl_sel_t'(shift_word[1:0]);

  function automatic logic load_hit(input logic     rise,
                                    input dsl_sel_t sel,
                                    input dsl_sel_t want);
    load_hit = rise && (sel == want);
  endfunction

  // Latches stay writable in every power-down state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      if_ref_latch <= dsl_ref_latch_t'(LATCH_RESET);
    end else if (load_hit(strobe_rise, word_sel, SEL_IF_REF)) begin
      if_ref_latch <= dsl_ref_latch_t'(shift_word);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      if_fb_latch <= dsl_fb_latch_t'(LATCH_RESET);
    end else if (load_hit(strobe_rise, word_sel, SEL_IF_FB)) begin
      if_fb_latch <= dsl_fb_latch_t'(shift_word);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rf_reference_divider_latch <= dsl_ref_latch_t'(LATCH_RESET);
    end else if (load_hit(strobe_rise, word_sel, SEL_RF_REF)) begin
      rf_reference_divider_latch <= dsl_ref_latch_t'(shift_word);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rf_feedback_divider_latch <= dsl_fb_latch_t'(LATCH_RESET);
    end else if (load_hit(strobe_rise, word_sel, SEL_RF_FB)) begin
      rf_feedback_divider_latch <= dsl_fb_latch_t'(shift_word);
    end
  end

  // Power-down sequencing. The state follows the latched bits, so a new
  // latch value reaches the state two cycles after the strobe rise is seen.
  function automatic dsl_pd_state_t pd_step(input dsl_pd_state_t state,
                                            input logic          pd_bit,
                                            input logic          tri_bit);
    unique case (state)
      PD_ACTIVE: begin
        if (!pd_bit) begin
          pd_step = PD_ACTIVE;
        end else if (tri_bit) begin
          pd_step = PD_DOWN;
        end else begin
          pd_step = PD_DRAIN;
        end
      end
      PD_DRAIN: pd_step = pd_bit ? PD_DOWN : PD_ACTIVE;
      PD_DOWN:  pd_step = pd_bit ? PD_DOWN : PD_ACTIVE;
      default:  pd_step = PD_ACTIVE;
    endcase
  endfunction

  assign next_if_pd = pd_step(if_pd_state, if_fb_latch.powerdown,
                              if_ref_latch.pump_tristate);
  assign next_rf_pd = pd_step(rf_pd_state, rf_feedback_divider_latch.powerdown,
                              rf_reference_divider_latch.pump_tristate);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      if_pd_state <= PD_ACTIVE;
      rf_pd_state <= PD_ACTIVE;
    end else begin
      if_pd_state <= next_if_pd;
      rf_pd_state <= next_rf_pd;
    end
  end

  assign mux_mode = dsl_mux_t'({rf_reference_divider_latch.out_sel_hi,
                                rf_reference_divider_latch.out_sel_lo,
                                if_ref_latch.out_sel_hi,
                                if_ref_latch.out_sel_lo});

  assign if_reset_mode = (mux_mode == MUX_IF_RST) || (mux_mode == MUX_BOTH_RST);
  assign rf_reset_mode = (mux_mode == MUX_RF_RST) || (mux_mode == MUX_BOTH_RST);

  // Either gain bit holds the fast-lock switch closed
  assign fastlock_on = if_fb_latch.gain | rf_feedback_divider_latch.gain;

  function automatic dsl_side_t side_build(input dsl_ref_latch_t ref_l,
                                           input dsl_fb_latch_t  fb_l,
                                           input dsl_pd_state_t  state,
                                           input logic           reset_mode);
    dsl_side_t s;
    s.pump_tristate = ref_l.pump_tristate | reset_mode | (state != PD_ACTIVE);
    s.pump_current  = fb_l.gain ? CP_CURRENT_MAX : ref_l.pump_current;
    s.pd_polarity   = ref_l.pd_polarity;
    s.counters_load = reset_mode | (state == PD_DOWN);
    s.input_debias  = (state == PD_DOWN);
    s.fastlock      = fb_l.gain;
    s.prescaler_mod = prescaler_lookup(fb_l.prescale_sel);
    s.ref_count     = ref_l.ref_count;
    s.b_count       = fb_l.b_count;
    s.a_count       = fb_l.a_count;
    side_build = s;
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      if_side <= '0;
    end else begin
      if_side <= side_build(if_ref_latch, if_fb_latch, next_if_pd, if_reset_mode);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rf_side <= '0;
    end else begin
      rf_side <= side_build(rf_reference_divider_latch, rf_feedback_divider_latch,
                            next_rf_pd, rf_reset_mode);
    end
  end

  // One pulse at reset release restarts both counters of a side together
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      if_reset_d       <= 1'b0;
      rf_reset_d       <= 1'b0;
      if_counter_align <= 1'b0;
      rf_counter_align <= 1'b0;
    end else begin
      if_reset_d       <= if_reset_mode;
      rf_reset_d       <= rf_reset_mode;
      if_counter_align <= if_reset_d & ~if_reset_mode;
      rf_counter_align <= rf_reset_d & ~rf_reset_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ref_osc_disable <= 1'b0;
    end else begin
      ref_osc_disable <= (next_if_pd == PD_DOWN) && (next_rf_pd == PD_DOWN);
    end
  end

  // Analog lock modes are open drain: release for high, sink for low
  always_comb begin
    next_pin_o  = 1'b0;
    next_pin_oe = 1'b1;
    unique case (mux_mode)
      MUX_IF_DLOCK: next_pin_o = if_dlock;
      MUX_RF_DLOCK: next_pin_o = rf_dlock;
      MUX_IF_ALOCK: next_pin_oe = ~(if_alock & ~pfd_pulse);
      MUX_RF_ALOCK: next_pin_oe = ~(rf_alock & ~pfd_pulse);
      MUX_BOTH_ALOCK: next_pin_oe = ~(if_alock & rf_alock & ~pfd_pulse);
      MUX_FASTLOCK: next_pin_oe = fastlock_on;
      default: begin
        next_pin_o  = 1'b0;
        next_pin_oe = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      multiplexed_output_pin_o  <= 1'b0;
      multiplexed_output_pin_oe <= 1'b1;
    end else begin
      multiplexed_output_pin_o  <= next_pin_o;
      multiplexed_output_pin_oe <= next_pin_oe;
    end
  end

endmodule

// File: bench/dsl_host_model.sv
`timescale 1ns/10ps
module dsl_host_model (
  output logic serial_clk,
  output logic serial_data,
  output logic latch_load_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_load_strobe = 1'b0;
  end
  // Clock stands still between frames; data is flipped after a frame so stale bits never match
  task automatic send(input logic [23:0] w);
    #1.3;
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #3 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
    end
    serial_data = ~w[0];
    #3 latch_load_strobe = 1'b1;
    #80 latch_load_strobe = 1'b0;
  endtask
endmodule

// File: bench/dsl_ctrl_assertions.sv
`timescale 1ns/10ps
module dsl_ctrl_checker
  import dsl_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset_n,
  input wire dsl_ref_latch_t if_ref_latch,
  input wire dsl_fb_latch_t  if_fb_latch,
  input wire dsl_ref_latch_t rf_reference_divider_latch,
  input wire dsl_fb_latch_t  rf_feedback_divider_latch,
  input wire dsl_side_t      if_side,
  input wire dsl_side_t      rf_side,
  input wire logic           ref_osc_disable,
  input wire dsl_pd_state_t  if_pd_state,
  input wire dsl_pd_state_t  rf_pd_state,
  input wire logic           multiplexed_output_pin_o,
  input wire logic           multiplexed_output_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic [3:0] mux = {rf_reference_divider_latch.out_sel_hi,
    rf_reference_divider_latch.out_sel_lo, if_ref_latch.out_sel_hi, if_ref_latch.out_sel_lo};

  if_drain_a: assert property (if_pd_state == PD_DRAIN
    && if_fb_latch.powerdown |=> if_pd_state == PD_DOWN)
    else $error("IF drain did not end in power-down");
  rf_drain_a: assert property (rf_pd_state == PD_DRAIN
    && rf_feedback_divider_latch.powerdown |=> rf_pd_state == PD_DOWN)
    else $error("RF drain did not end in power-down");
  drain_tri_a: assert property (if_pd_state == PD_DRAIN |-> if_side.pump_tristate)
    else $error("IF pump active while draining");
  rf_async_a: assert property (rf_pd_state == PD_ACTIVE
    && rf_reference_divider_latch.pump_tristate ##1 rf_pd_state != PD_ACTIVE
    |-> rf_pd_state == PD_DOWN)
    else $error("RF power-down not immediate");
  if_down_a: assert property ((if_pd_state == PD_DOWN)[*2] |->
    if_side.counters_load && if_side.input_debias)
    else $error("IF down without divider load");
  osc_on_a: assert property ((if_pd_state == PD_ACTIVE)[*3] |-> !ref_osc_disable)
    else $error("Oscillator off with IF active");
  gain_cur_a: assert property (if_fb_latch.gain[*3] |->
    if_side.pump_current == CP_CURRENT_MAX)
    else $error("Fast-lock current not maximum");
  rf_tri_a: assert property (rf_reference_divider_latch.pump_tristate[*3] |->
    rf_side.pump_tristate)
    else $error("RF pump not three-state");
  fast_pin_a: assert property ((mux == MUX_FASTLOCK && rf_feedback_divider_latch.gain)[*3]
    |-> multiplexed_output_pin_oe && !multiplexed_output_pin_o)
    else $error("Fast-lock pin not sinking");
  if_rst_a: assert property ((mux == MUX_IF_RST)[*3] |-> if_side.counters_load
    && if_side.pump_tristate)
    else $error("IF counter reset not applied");
  resume_a: assert property ($fell(if_fb_latch.powerdown) |->
    ##[1:2] if_pd_state == PD_ACTIVE)
    else $error("IF did not resume");
  cov_drain: cover property (if_pd_state == PD_DRAIN);
  cov_osc: cover property (ref_osc_disable);
  cov_fast: cover property (mux == MUX_FASTLOCK && multiplexed_output_pin_oe);
endmodule

bind dsl_ctrl dsl_ctrl_checker u_chk (.clk(clk), .reset_n(reset_n),
  .if_ref_latch(if_ref_latch), .if_fb_latch(if_fb_latch),
  .rf_reference_divider_latch(rf_reference_divider_latch),
  .rf_feedback_divider_latch(rf_feedback_divider_latch), .if_side(if_side),
  .rf_side(rf_side), .ref_osc_disable(ref_osc_disable), .if_pd_state(if_pd_state),
  .rf_pd_state(rf_pd_state), .multiplexed_output_pin_o(multiplexed_output_pin_o),
  .multiplexed_output_pin_oe(multiplexed_output_pin_oe));

// File: bench/tb_dual_synth_latch_control.sv
`timescale 1ns/10ps
module tb_dual_synth_latch_control;
  import dsl_pkg::*;
  logic           clk, reset_n, if_dl, rf_dl, if_al, rf_al, pfd;
  wire            sclk, sdat, strobe;
  dsl_ref_latch_t if_rl, rf_rl, r;
  dsl_fb_latch_t  if_fl, rf_fl, f;
  dsl_side_t      if_sd, rf_sd;
  dsl_pd_state_t  if_pd, rf_pd;
  logic           if_ca, rf_ca, osc_off, pin_o, pin_oe;
  logic [23:0]    w;
  logic [23:0]    mdl [4];
  int             fails = 0;
  int             num_checks = 0;
  int             seed = 32'h09a1;
  int             n;
  int             nr;
  logic [6:0]     presc_tab [4] = '{PRESC_SEL0, PRESC_SEL1, PRESC_SEL2, PRESC_SEL3};
  // Open-drain pin with a pull-up on the board
  wire            pin_lvl = pin_oe ? pin_o : 1'b1;

  dsl_host_model u_host (.serial_clk(sclk), .serial_data(sdat), .latch_load_strobe(strobe));
  dsl_ctrl u_dut (.clk(clk), .reset_n(reset_n), .serial_clk(sclk), .serial_data(sdat),
    .latch_load_strobe(strobe), .if_dlock_in(if_dl), .rf_dlock_in(rf_dl),
    .if_alock_in(if_al), .rf_alock_in(rf_al), .pfd_pulse_in(pfd),
    .if_ref_latch(if_rl), .if_fb_latch(if_fl), .rf_reference_divider_latch(rf_rl),
    .rf_feedback_divider_latch(rf_fl), .if_side(if_sd), .rf_side(rf_sd),
    .if_counter_align(if_ca), .rf_counter_align(rf_ca), .ref_osc_disable(osc_off),
    .if_pd_state(if_pd), .rf_pd_state(rf_pd), .multiplexed_output_pin_o(pin_o),
    .multiplexed_output_pin_oe(pin_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [23:0] x);
    u_host.send(x);
    mdl[x[1:0]] = x;
    repeat (6) @(posedge clk);
  endtask

  task automatic chk_latches();
    chk("if_ref", if_rl, mdl[0]);
    chk("if_fb", if_fl, mdl[1]);
    chk("rf_ref", rf_rl, mdl[2]);
    chk("rf_fb", rf_fl, mdl[3]);
  endtask

  task automatic set_mux(input logic [3:0] m);
    r = '0;
    {r.out_sel_hi, r.out_sel_lo} = m[1:0];
    wr(r);
    {r.out_sel_hi, r.out_sel_lo} = m[3:2];
    r.sel = 2'b10;
    wr(r);
  endtask

  // Side 0 is IF, side 1 is RF; the drain step is watched while the word goes out
  task automatic pdn(input logic s, input logic tri_bit, input logic pd);
    r = '0;
    r.pump_tristate = tri_bit;
    r.sel = {s, 1'b0};
    wr(r);
    f = '0;
    f.powerdown = pd;
    f.sel = {s, 1'b1};
    n = 0;
    fork
      u_host.send(f);
      for (int i = 0; i < 16; i++) begin
        @(posedge clk);
        #1 n += ((s ? rf_pd : if_pd) === PD_DRAIN);
      end
    join
    mdl[f.sel] = f;
    chk("drain", n, pd && !tri_bit);
    chk("pd_state", s ? rf_pd : if_pd, pd ? PD_DOWN : PD_ACTIVE);
    chk("load", s ? rf_sd.counters_load : if_sd.counters_load, pd);
    chk("debias", s ? rf_sd.input_debias : if_sd.input_debias, pd);
  endtask

  initial begin
    reset_n = 1'b0;
    {if_dl, rf_dl, if_al, rf_al, pfd} = '0;
    mdl = '{default: '0};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_latches();
    for (int i = 0; i < 12; i++) begin
      w = 24'($random(seed));
      w[1:0] = 2'(i);
      wr(w);
      chk_latches();
    end
    set_mux(MUX_LOW);
    for (int p = 0; p < 4; p++) begin
      f = 24'($random(seed));
      {f.gain, f.powerdown, f.prescale_sel, f.sel} = {2'b00, 2'(p), 2'b01};
      wr(f);
      chk("presc", if_sd.prescaler_mod, presc_tab[p]);
      chk("b_count", if_sd.b_count, f.b_count);
      chk("a_count", if_sd.a_count, f.a_count);
      r = 24'($random(seed));
      {r.out_sel_hi, r.out_sel_lo, r.pump_tristate, r.pd_polarity} = {3'(p), 1'b1};
      r.sel = 2'b00;
      wr(r);
      chk("cur", if_sd.pump_current, r.pump_current);
      chk("tri", if_sd.pump_tristate, r.pump_tristate);
      chk("pol", if_sd.pd_polarity, 1'b1);
      chk("r_count", if_sd.ref_count, r.ref_count);
    end
    f = 24'($random(seed));
    {f.gain, f.powerdown, f.prescale_sel, f.sel} = 6'b001111;
    wr(f);
    chk("rf_presc", rf_sd.prescaler_mod, presc_tab[3]);
    chk("rf_b", rf_sd.b_count, f.b_count);
    r = 24'($random(seed));
    {r.out_sel_hi, r.out_sel_lo, r.pump_tristate, r.sel} = 5'b00010;
    wr(r);
    chk("rf_cur", rf_sd.pump_current, r.pump_current);
    chk("rf_r_count", rf_sd.ref_count, r.ref_count);
    f = '0;
    {f.gain, f.sel} = 3'b101;
    wr(f);
    chk("fast_cur", if_sd.pump_current, CP_CURRENT_MAX);
    chk("fast_on", if_sd.fastlock, 1'b1);
    f.gain = 1'b0;
    wr(f);
    chk("fast_off", if_sd.fastlock, 1'b0);
    set_mux(MUX_FASTLOCK);
    {f.gain, f.sel} = 3'b111;
    wr(f);
    chk("fl_pin", pin_lvl, 1'b0);
    f.gain = 1'b0;
    wr(f);
    chk("fl_pin", pin_lvl, 1'b1);
    set_mux(MUX_BOTH_ALOCK);
    {if_al, rf_al} <= 2'b10;
    repeat (6) @(posedge clk);
    chk("alock", pin_lvl, 1'b0);
    rf_al <= 1'b1;
    repeat (6) @(posedge clk);
    chk("alock", pin_lvl, 1'b1);
    pfd <= 1'b1;
    repeat (6) @(posedge clk);
    chk("alock", pin_lvl, 1'b0);
    pfd <= 1'b0;
    rf_al <= 1'b0;
    set_mux(MUX_IF_ALOCK);
    chk("alock_if", pin_lvl, 1'b1);
    set_mux(MUX_RF_ALOCK);
    chk("alock_rf", pin_lvl, 1'b0);
    rf_al <= 1'b1;
    repeat (6) @(posedge clk);
    chk("alock_rf", pin_lvl, 1'b1);
    set_mux(MUX_IF_RST);
    chk("rst_load", if_sd.counters_load, 1'b1);
    chk("rst_tri", if_sd.pump_tristate, 1'b1);
    chk("rf_free", rf_sd.counters_load, 1'b0);
    set_mux(MUX_BOTH_RST);
    chk("rf_load", rf_sd.counters_load, 1'b1);
    chk("rf_tri", rf_sd.pump_tristate, 1'b1);
    n = 0;
    nr = 0;
    fork
      set_mux(MUX_LOW);
      repeat (40) @(posedge clk) #1 begin
        n += (if_ca === 1'b1);
        nr += (rf_ca === 1'b1);
      end
    join
    chk("align", n, 1);
    chk("rf_align", nr, 1);
    pdn(1'b0, 1'b0, 1'b1);
    pdn(1'b1, 1'b1, 1'b1);
    chk("osc", osc_off, 1'b1);
    w = 24'($random(seed));
    w[1:0] = 2'b00;
    wr(w);
    chk_latches();
    pdn(1'b0, 1'b0, 1'b0);
    chk("osc", osc_off, 1'b0);
    pdn(1'b1, 1'b1, 1'b0);
    complete_run();
  end
endmodule
